/* verilog/rsc_pkg.sv */
package rsc_pkg;

    localparam int unsigned CLK_KHZ = 100000;
    // Durations in nanoseconds, as printed in milliseconds times 1e6
    localparam longint unsigned DESTRUCTIVE_SELFTEST_NS = 64'd5730000;
    localparam longint unsigned DESTRUCTIVE_PLAIN_NS = 64'd111000;
    localparam longint unsigned EXTERNAL_LONG_NS = 64'd5729000;
    localparam longint unsigned FUNCTIONAL_LONG_NS = 64'd110000;
    localparam longint unsigned FUNCTIONAL_SHORT_NS = 64'd4000;
    localparam longint unsigned CLK_PERIOD_NS = 64'd1000000 / CLK_KHZ;

    // Least times round up to whole cycles
    localparam longint unsigned DESTRUCTIVE_SELFTEST_CYC =
        (DESTRUCTIVE_SELFTEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint unsigned DESTRUCTIVE_PLAIN_CYC =
        (DESTRUCTIVE_PLAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint unsigned EXTERNAL_LONG_CYC =
        (EXTERNAL_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint unsigned FUNCTIONAL_LONG_CYC =
        (FUNCTIONAL_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint unsigned FUNCTIONAL_SHORT_CYC =
        (FUNCTIONAL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
    // Last count of the settle wait after the pin is let go
    localparam logic [CNT_W-1:0] HOLD_LAST = 20'h00002;

    typedef enum logic [4:0] {
        SEQ_NONE = 5'h00,
        SEQ_DESTR_SELFTEST = 5'h01,
        SEQ_DESTR_PLAIN = 5'h02,
        SEQ_EXT_LONG = 5'h04,
        SEQ_FUNC_LONG = 5'h08,
        SEQ_FUNC_SHORT = 5'h10
    } rsc_kind_t;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_PHASE = 4'h2,
        ST_HOLD = 4'h4,
        ST_RELEASE = 4'h8
    } rsc_state_t;

    // Requests into the sequencer, one-cycle pulses
    typedef struct packed {
        logic destr;
        logic selftest_en;
        logic func_long;
        logic func_short;
        logic func_pin_en;
    } rsc_req_t;

    // Open-drain pin: oe_n low means pulling the pin low
    typedef struct packed {
        logic pin_o;
        logic pin_oe_n;
    } rsc_pin_t;

endpackage : rsc_pkg

/* verilog/rsc_sync2.sv */
`timescale 1ns/1ns
module rsc_sync2 (
    input wire logic clk,
    input wire logic nrst,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // Reset value high: pin idles released at the pullup level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : rsc_sync2

/* verilog/rsc_sequencer.sv */
`timescale 1ns/1ns
module rsc_sequencer
    import rsc_pkg::*;
#(
    parameter logic [CNT_W-1:0] DESTR_SELFTEST_CYC =
        CNT_W'(DESTRUCTIVE_SELFTEST_CYC),
    parameter logic [CNT_W-1:0] DESTR_PLAIN_CYC =
        CNT_W'(DESTRUCTIVE_PLAIN_CYC),
    parameter logic [CNT_W-1:0] EXT_LONG_CYC = CNT_W'(EXTERNAL_LONG_CYC),
    parameter logic [CNT_W-1:0] FUNC_LONG_CYC =
        CNT_W'(FUNCTIONAL_LONG_CYC)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire rsc_req_t req,
    input wire logic reset_pin_i,
    output rsc_pin_t reset_pin,
    output logic normal_run_mode,
    output logic first_fetch,
    output logic final_internal_phase,
    output rsc_kind_t active_kind
);

    ////////////////////////////////////////////////////////////////////
    logic pin_s;
    rsc_state_t state_q, state_d;
    rsc_kind_t kind_q, kind_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic drive_q, drive_d;
    logic run_q, fetch_q, final_q;
    logic pin_oe_n_q;

    rsc_sync2 u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .d(reset_pin_i),
        .q(pin_s)
    );

    // State decode shared by the next-state logic and the outputs
    wire in_run = (state_q == ST_RUN);
    wire in_release = (state_q == ST_RELEASE);
    wire hold_done = (cnt_q == HOLD_LAST);
    wire next_run = (state_d == ST_RUN);
    wire next_final = (state_d == ST_HOLD) || (state_d == ST_RELEASE);

    // While we pull the pin ourselves its low level tells us nothing
    wire ext_low = !pin_s && !drive_q;
    wire any_func = req.func_long || req.func_short;
    wire start_destr = req.destr;
    wire start_ext = ext_low && in_run;
    wire start_func = any_func && !start_destr && !start_ext;
    wire start_any = start_destr || start_ext || start_func;

    wire rsc_kind_t destr_kind =
        req.selftest_en ? SEQ_DESTR_SELFTEST : SEQ_DESTR_PLAIN;
    wire rsc_kind_t func_kind =
        req.func_long ? SEQ_FUNC_LONG : SEQ_FUNC_SHORT;
    wire rsc_kind_t new_kind =
        start_destr ? destr_kind : (start_ext ? SEQ_EXT_LONG : func_kind);

    wire [CNT_W-1:0] func_short_cyc = CNT_W'(FUNCTIONAL_SHORT_CYC);
    wire [CNT_W-1:0] load_cnt =
        (new_kind == SEQ_DESTR_SELFTEST) ? DESTR_SELFTEST_CYC :
        (new_kind == SEQ_DESTR_PLAIN) ? DESTR_PLAIN_CYC :
        (new_kind == SEQ_EXT_LONG) ? EXT_LONG_CYC :
        (new_kind == SEQ_FUNC_LONG) ? FUNC_LONG_CYC :
        func_short_cyc;

    // Destructive and external always pull; functional only if enabled
    wire new_drive = start_destr || start_ext || req.func_pin_en;
    wire phase_done = (cnt_q == CNT_ONE);
    // Pin sampled only after our own pull has been released
    wire pin_high = pin_s;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        cnt_d = cnt_q;
        drive_d = drive_q;
        case (state_q)
            ST_RUN: begin
                if (start_any) begin
                    state_d = ST_PHASE;
                    kind_d = new_kind;
                    cnt_d = load_cnt;
                    drive_d = new_drive;
                end
            end
            ST_PHASE: begin
                if (start_destr) begin
                    // A destructive event restarts the sequence
                    kind_d = destr_kind;
                    cnt_d = start_destr ? load_cnt : cnt_q;
                    drive_d = 1'b1;
                end else if (phase_done) begin
                    state_d = ST_HOLD;
                    cnt_d = CNT_ZERO;
                    drive_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            ST_HOLD: begin
                // Give the released pin two sync stages to settle
                if (start_destr) begin
                    state_d = ST_PHASE;
                    kind_d = destr_kind;
                    cnt_d = load_cnt;
                    drive_d = 1'b1;
                end else if (hold_done) begin
                    state_d = ST_RELEASE;
                end else begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            ST_RELEASE: begin
                // External generator still low: stay in reset
                if (start_destr) begin
                    state_d = ST_PHASE;
                    kind_d = destr_kind;
                    cnt_d = load_cnt;
                    drive_d = 1'b1;
                end else if (pin_high) begin
                    state_d = ST_RUN;
                    kind_d = SEQ_NONE;
                    cnt_d = CNT_ZERO;
                end
            end
            default: begin
                state_d = ST_RUN;
                kind_d = SEQ_NONE;
                cnt_d = CNT_ZERO;
                drive_d = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Power-on starts a destructive sequence without self-test
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_PHASE;
            kind_q <= SEQ_DESTR_PLAIN;
            cnt_q <= DESTR_PLAIN_CYC;
            drive_q <= 1'b1;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            drive_q <= drive_d;
        end
    end

    wire enter_run = in_release && next_run;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_q <= 1'b0;
            fetch_q <= 1'b0;
            final_q <= 1'b0;
        end else begin
            run_q <= next_run;
            fetch_q <= enter_run;
            final_q <= next_final;
        end
    end

    // Pad enable kept in its own flop so the pin sees no gate delay
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_oe_n_q <= 1'b0;
        end else begin
            pin_oe_n_q <= !drive_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Never drive high; the pullup makes the high level
    assign reset_pin.pin_o = 1'b0;
    assign reset_pin.pin_oe_n = pin_oe_n_q;
    assign normal_run_mode = run_q;
    assign first_fetch = fetch_q;
    assign final_internal_phase = final_q;
    assign active_kind = kind_q;

endmodule : rsc_sequencer

/* dv/rsc_sequencer_chk.sv */
`timescale 1ns/1ns
module rsc_sequencer_chk
    import rsc_pkg::*;
#(
    parameter int DESTR_SELFTEST_CYC = 20,
    parameter int DESTR_PLAIN_CYC = 20,
    parameter int EXT_LONG_CYC = 20,
    parameter int FUNC_LONG_CYC = 20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire rsc_req_t req,
    input wire logic reset_pin_i,
    input wire rsc_pin_t reset_pin,
    input wire logic normal_run_mode,
    input wire logic first_fetch,
    input wire logic final_internal_phase,
    input wire rsc_kind_t active_kind
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    int low_q;
    int need;
    // Kind is still held when the pin is let go, so it picks the length
    assign need = active_kind == SEQ_FUNC_SHORT ? int'(FUNCTIONAL_SHORT_CYC) :
        active_kind == SEQ_FUNC_LONG ? FUNC_LONG_CYC :
        active_kind == SEQ_EXT_LONG ? EXT_LONG_CYC :
        active_kind == SEQ_DESTR_SELFTEST ? DESTR_SELFTEST_CYC :
        DESTR_PLAIN_CYC;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_q <= 0;
        end else begin
            low_q <= reset_pin.pin_oe_n ? 0 : low_q + 1;
        end
    end
    a_pin_low_only: assert property (reset_pin.pin_o == 1'b0)
        else $error("pin driven high");
    a_pull_length: assert property (
        $rose(reset_pin.pin_oe_n) |-> low_q >= need)
        else $error("pin released too early");
    a_release_final: assert property ($rose(reset_pin.pin_oe_n)
        |-> final_internal_phase && !normal_run_mode)
        else $error("release outside final phase");
    a_run_pin_free: assert property (normal_run_mode
        |-> reset_pin.pin_oe_n && active_kind == SEQ_NONE)
        else $error("run while still in sequence");
    a_fetch_pulse: assert property ($rose(normal_run_mode)
        |-> first_fetch ##1 !first_fetch) else $error("fetch pulse wrong");
    a_fetch_in_run: assert property (first_fetch
        |-> normal_run_mode && !$past(normal_run_mode))
        else $error("fetch outside run start");
    a_ext_extends: assert property ((final_internal_phase &&
        !reset_pin_i)[*3] |=> !normal_run_mode) else $error("run while held");
    a_func_no_pin: assert property (normal_run_mode && reset_pin_i &&
        req.func_short && !req.func_long && !req.func_pin_en && !req.destr
        |=> reset_pin.pin_oe_n) else $error("pin pulled without enable");
    c_fetch: cover property ($rose(first_fetch));
    c_ext: cover property (active_kind == SEQ_EXT_LONG);
    c_hold: cover property (final_internal_phase && !reset_pin_i);
endmodule : rsc_sequencer_chk

/* dv/rsc_ext_gen.sv */
`timescale 1ns/1ns
module rsc_ext_gen (
    input wire logic clk,
    input wire logic hold,
    output logic pull_n
);
    initial pull_n = 1'b1;
    // Board generator only sinks the line; the pullup gives high
    always @(posedge clk) begin
        pull_n <= !hold;
    end
endmodule : rsc_ext_gen

/* dv/test_reset_sequence_controller.sv */
`timescale 1ns/1ns
module test_reset_sequence_controller;
    import rsc_pkg::*;
    localparam int CYC = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ext_hold = 1'b0;
    logic ext_pull_n;
    logic pin;
    rsc_req_t req = '0;
    rsc_pin_t reset_pin;
    logic normal_run_mode, first_fetch, final_internal_phase;
    rsc_kind_t active_kind;
    int err_total = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    // Wired line with pullup: high only when nobody sinks it
    assign pin = reset_pin.pin_oe_n & ext_pull_n;
    rsc_sequencer #(.DESTR_SELFTEST_CYC(20'h00014),
        .DESTR_PLAIN_CYC(20'h00014), .EXT_LONG_CYC(20'h00014),
        .FUNC_LONG_CYC(20'h00014)) i_rsc_sequencer (.clk(clk), .nrst(nrst),
        .req(req), .reset_pin_i(pin), .reset_pin(reset_pin),
        .normal_run_mode(normal_run_mode), .first_fetch(first_fetch),
        .final_internal_phase(final_internal_phase),
        .active_kind(active_kind));
    rsc_ext_gen i_rsc_ext_gen (.clk(clk), .hold(ext_hold),
        .pull_n(ext_pull_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("mismatches %0d compares %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    // Request, hold the board line, then count pulled cycles until run
    task automatic go(input rsc_req_t r, input int hold, output int low,
        output int tot, output rsc_kind_t k);
        low = 0;
        tot = 0;
        k = SEQ_NONE;
        @(posedge clk);
        req <= r;
        ext_hold <= (hold > 0);
        @(posedge clk);
        req <= '0;
        #1;
        // The pull starts at the edge that takes the request
        if (reset_pin.pin_oe_n === 1'b0) low++;
        while (tot < 3000 && (tot < 6 || normal_run_mode !== 1'b1)) begin
            @(posedge clk);
            ext_hold <= (tot < hold);
            #1;
            tot++;
            if (reset_pin.pin_oe_n === 1'b0) low++;
            if (normal_run_mode !== 1'b1) k = active_kind;
        end
        chk(first_fetch, 1'b1);
        chk(active_kind, SEQ_NONE);
        chk(final_internal_phase, 1'b0);
        chk(reset_pin.pin_o, 1'b0);
    endtask : go
    task automatic t_power();
        int low, tot;
        rsc_kind_t k;
        go('0, 0, low, tot, k);
        chk(k, SEQ_DESTR_PLAIN);
    endtask : t_power
    task automatic t_func(input logic lng, input logic pe);
        rsc_req_t r;
        int low, tot;
        rsc_kind_t k;
        r = '0;
        r.func_long = lng;
        r.func_short = !lng;
        r.func_pin_en = pe;
        go(r, 0, low, tot, k);
        chk(low, pe ? (lng ? CYC : int'(FUNCTIONAL_SHORT_CYC)) : 0);
        chk(k, lng ? SEQ_FUNC_LONG : SEQ_FUNC_SHORT);
    endtask : t_func
    task automatic t_destr(input logic st);
        rsc_req_t r;
        int low, tot;
        rsc_kind_t k;
        r = '0;
        r.destr = 1'b1;
        r.selftest_en = st;
        go(r, 0, low, tot, k);
        chk(low, CYC);
        chk(k, st ? SEQ_DESTR_SELFTEST : SEQ_DESTR_PLAIN);
    endtask : t_destr
    task automatic t_ext();
        int low, tot;
        rsc_kind_t k;
        go('0, 4, low, tot, k);
        chk(low, CYC);
        chk(k, SEQ_EXT_LONG);
    endtask : t_ext
    task automatic t_extend();
        rsc_req_t r;
        int low, tot;
        rsc_kind_t k;
        r = '0;
        r.func_short = 1'b1;
        r.func_pin_en = 1'b1;
        go(r, 600, low, tot, k);
        chk(tot > 600, 1);
        chk(low, int'(FUNCTIONAL_SHORT_CYC));
    endtask : t_extend
    // Destructive request inside a functional sequence restarts it
    task automatic t_preempt();
        rsc_req_t f;
        rsc_req_t r;
        int low, tot;
        rsc_kind_t k;
        f = '0;
        f.func_short = 1'b1;
        r = '0;
        r.destr = 1'b1;
        @(posedge clk);
        req <= f;
        go(r, 0, low, tot, k);
        chk(low, CYC);
        chk(k, SEQ_DESTR_PLAIN);
    endtask : t_preempt
    // Reset in mid-sequence: power-on values, then a fresh sequence
    task automatic t_reset();
        rsc_req_t f;
        int low, tot;
        rsc_kind_t k;
        f = '0;
        f.func_long = 1'b1;
        @(posedge clk);
        req <= f;
        @(posedge clk);
        req <= '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        chk(reset_pin.pin_oe_n, 1'b0);
        chk(normal_run_mode, 1'b0);
        chk(first_fetch, 1'b0);
        chk(final_internal_phase, 1'b0);
        chk(active_kind, SEQ_DESTR_PLAIN);
        @(posedge clk);
        nrst <= 1'b1;
        go('0, 0, low, tot, k);
        chk(k, SEQ_DESTR_PLAIN);
    endtask : t_reset
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_power();
        t_func(1'b0, 1'b1);
        t_func(1'b0, 1'b0);
        t_func(1'b1, 1'b1);
        t_func(1'b1, 1'b0);
        t_destr(1'b0);
        t_destr(1'b1);
        t_ext();
        t_preempt();
        t_extend();
        t_reset();
        conclude();
    end
    initial begin
        #100000;
        err_total++;
        conclude();
    end
endmodule : test_reset_sequence_controller
bind rsc_sequencer rsc_sequencer_chk #(
    .DESTR_SELFTEST_CYC(DESTR_SELFTEST_CYC),
    .DESTR_PLAIN_CYC(DESTR_PLAIN_CYC), .EXT_LONG_CYC(EXT_LONG_CYC),
    .FUNC_LONG_CYC(FUNC_LONG_CYC)) i_chk (.clk(clk), .nrst(nrst), .req(req),
    .reset_pin_i(reset_pin_i), .reset_pin(reset_pin),
    .normal_run_mode(normal_run_mode), .first_fetch(first_fetch),
    .final_internal_phase(final_internal_phase), .active_kind(active_kind));
